// File: hdl/acq_pkg.sv
// Shared constants for the acquisition trigger and pacing block.
// Assumes one 40 MHz board clock and an AHB-Lite register slave.
package acq_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_SLOT_NS = 1000;
  localparam int US_CYC = CONV_SLOT_NS / CLK_PERIOD_NS;
  localparam int COARSE_US = 16;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CHCFG = 8'h08;
  localparam logic [7:0] OFS_ATRIG = 8'h0C;
  localparam logic [7:0] OFS_PATTERN = 8'h10;
  localparam logic [7:0] OFS_CNT_LO = 8'h14;
  localparam logic [7:0] OFS_CNT_HI = 8'h18;
  localparam logic [7:0] OFS_ACQCFG = 8'h1C;
  localparam logic [7:0] OFS_SCANCNT = 8'h20;
  localparam logic [7:0] OFS_SCANPER = 8'h24;
  localparam logic [7:0] OFS_DACCFG = 8'h28;
  localparam logic [7:0] OFS_DACPER = 8'h2C;
  localparam logic [7:0] OFS_DACIMM = 8'h30;

  // Field positions
  localparam int CTRL_ARM = 0;
  localparam int CTRL_HALT = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 8;
  localparam int CTRL_DMODE = 11;
  localparam int CTRL_CMODE = 13;
  localparam int CTRL_EXTSCAN = 15;
  localparam int CTRL_AFALL = 16;
  localparam int CTRL_ACHAN = 17;
  localparam int CTRL_COARSE = 23;
  localparam int CHCFG_IDX = 16;
  localparam int ACQ_NCHAN = 8;
  localparam int DAC_STREAM = 8;
  localparam int DAC_CALSEL = 12;
  localparam int DAC_CALWR = 14;
  localparam int DACIMM_IDX = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ACQCFG_RST = 32'h0000_0100;
  localparam logic [31:0] SCANPER_RST = 32'h0000_0001;
  localparam logic [31:0] DACPER_RST = 32'h0000_0001;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PRE = 2'b01, ST_POST = 2'b11} acq_state_e;
  typedef enum logic [2:0] {
    M_NOPRE_STOP = 3'h0, M_FIXPRE_STOP = 3'h1, M_NOPRE_INF = 3'h2,
    M_FIXPRE_INF = 3'h3, M_VARPRE_STOP = 3'h4, M_VARPRE_INF = 3'h5
  } acq_mode_e;
  typedef enum logic [2:0] {
    SRC_DIGITAL = 3'h0, SRC_ANALOG = 3'h1, SRC_PATTERN = 3'h2,
    SRC_COUNTER = 3'h3, SRC_OTHER = 3'h4
  } trig_src_e;

endpackage : acq_pkg

// File: hdl/acq_trigger_pacing.sv
// Trigger detection, acquisition sequencing and converter pacing.
// Assumes AHB-Lite master on REF_CLK, ADC/DAC and DMA on the same clock.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module acq_trigger_pacing (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic DTRIG_IN,
  input wire logic [15:0] DIN,
  input wire logic EXT_CLK,
  input wire logic [31:0] CNT_VALUE,
  input wire logic ADC_VALID,
  input wire logic [15:0] ADC_DATA,
  input wire logic [5:0] ADC_SAMPLE_CHAN,
  output logic ADC_CONVERT,
  output logic [5:0] ADC_CHAN,
  output logic [2:0] ADC_RANGE,
  output logic ADC_DIFF,
  output logic SAMPLE_VALID,
  output logic [15:0] SAMPLE_DATA,
  output logic TRIG_PULSE,
  output logic [3:0] DAC_UPDATE,
  output logic [3:0] DAC_IMM_WE,
  output logic [15:0] DAC_IMM_DATA,
  output logic [1:0] CAL_SEL,
  output logic [1:0] CAL_WR_TABLE,
  output logic CAL_WR_OK
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic dtrig_m_r, dtrig_s_r, dtrig_d_r, ext_m_r, ext_s_r, ext_d_r;
  logic [15:0] din_m_r, din_s_r;
  logic [5:0] us_cnt_r;
  logic [3:0] coarse_cnt_r;
  logic us_tick_r, coarse_tick_r;
  logic wr_pend_r, arm_r, halt_r;
  logic [7:0] wr_addr_r;
  logic [31:0] ctrl_r, atrig_r, pattern_r, cnt_lo_r, cnt_hi_r, acqcfg_r;
  logic [31:0] scancnt_r, scanper_r, daccfg_r, dacper_r, rdata;
  logic [3:0] cfg_r [64];
  logic [5:0] cfg_idx_r;
  acq_pkg::acq_state_e state_r, state_nxt;
  acq_pkg::acq_mode_e mode;
  logic [15:0] mem_r [16];
  logic [4:0] wr_ptr_r, rd_ptr_r, fill, pre_eff;
  logic samp_in, is_fixed, is_nopre, is_inf, trig_fire, stop_fire, pre_ok;
  logic a_ch, a_armed_r, a_hit, d_hit, p_hit, c_hit, start_cond, stop_cond;
  logic [16:0] thr_plus, smp_plus;
  logic [6:0] nchan, chan_idx_r;
  logic conv_busy_r, scan_tmr, dac_tmr, scan_pulse, ext_rise, conv_wait_r;
  logic [31:0] scans_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dtrig_m_r <= 1'b0;
      dtrig_s_r <= 1'b0;
      dtrig_d_r <= 1'b0;
      ext_m_r <= 1'b0;
      ext_s_r <= 1'b0;
      ext_d_r <= 1'b0;
      din_m_r <= 16'h0000;
      din_s_r <= 16'h0000;
    end else begin
      dtrig_m_r <= DTRIG_IN;
      dtrig_s_r <= dtrig_m_r;
      dtrig_d_r <= dtrig_s_r;
      ext_m_r <= EXT_CLK;
      ext_s_r <= ext_m_r;
      ext_d_r <= ext_s_r;
      din_m_r <= DIN;
      din_s_r <= din_m_r;
    end
  end
  assign ext_rise = ext_s_r & ~ext_d_r;

  // Microsecond and coarse ticks
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      us_cnt_r <= 6'h00;
      us_tick_r <= 1'b0;
      coarse_cnt_r <= 4'h0;
      coarse_tick_r <= 1'b0;
    end else begin
      us_tick_r <= (us_cnt_r == 6'(acq_pkg::US_CYC - 1));
      us_cnt_r <= (us_cnt_r == 6'(acq_pkg::US_CYC - 1)) ? 6'h00 : us_cnt_r + 6'h01;
      coarse_tick_r <= us_tick_r && (coarse_cnt_r == 4'(acq_pkg::COARSE_US - 1));
      if (us_tick_r) begin
        coarse_cnt_r <= coarse_cnt_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, always OKAY
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_r <= HSEL && HTRANS[1] && HREADY && HWRITE;
      wr_addr_r <= HADDR[7:0];
      if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
        HRDATA <= rdata;
      end
    end
  end

  // Read decode; unmapped reads zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (HADDR[31:8] != 24'h00_0000) rdata = 32'h0000_0000;
    else if (HADDR[7:0] == acq_pkg::OFS_CTRL) rdata = ctrl_r;
    else if (HADDR[7:0] == acq_pkg::OFS_STATUS) rdata = {25'h0, fill, state_r};
    else if (HADDR[7:0] == acq_pkg::OFS_CHCFG) rdata = {10'h0, cfg_idx_r, 12'h0, cfg_r[cfg_idx_r]};
    else if (HADDR[7:0] == acq_pkg::OFS_ATRIG) rdata = atrig_r;
    else if (HADDR[7:0] == acq_pkg::OFS_PATTERN) rdata = pattern_r;
    else if (HADDR[7:0] == acq_pkg::OFS_CNT_LO) rdata = cnt_lo_r;
    else if (HADDR[7:0] == acq_pkg::OFS_CNT_HI) rdata = cnt_hi_r;
    else if (HADDR[7:0] == acq_pkg::OFS_ACQCFG) rdata = acqcfg_r;
    else if (HADDR[7:0] == acq_pkg::OFS_SCANCNT) rdata = scancnt_r;
    else if (HADDR[7:0] == acq_pkg::OFS_SCANPER) rdata = scanper_r;
    else if (HADDR[7:0] == acq_pkg::OFS_DACCFG) rdata = daccfg_r;
    else if (HADDR[7:0] == acq_pkg::OFS_DACPER) rdata = dacper_r;
  end

  // Register writes; arm and halt are self-clearing strobes
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r <= acq_pkg::CTRL_RST;
      atrig_r <= acq_pkg::ZERO_RST;
      pattern_r <= acq_pkg::ZERO_RST;
      cnt_lo_r <= acq_pkg::ZERO_RST;
      cnt_hi_r <= acq_pkg::ZERO_RST;
      acqcfg_r <= acq_pkg::ACQCFG_RST;
      scancnt_r <= acq_pkg::ZERO_RST;
      scanper_r <= acq_pkg::SCANPER_RST;
      daccfg_r <= acq_pkg::ZERO_RST;
      dacper_r <= acq_pkg::DACPER_RST;
      arm_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      arm_r <= 1'b0;
      halt_r <= 1'b0;
      if (wr_pend_r) begin
        if (wr_addr_r == acq_pkg::OFS_CTRL) begin
          ctrl_r <= {HWDATA[31:2], 2'b00};
          arm_r <= HWDATA[acq_pkg::CTRL_ARM];
          halt_r <= HWDATA[acq_pkg::CTRL_HALT];
        end
        else if (wr_addr_r == acq_pkg::OFS_ATRIG) atrig_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_PATTERN) pattern_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_CNT_LO) cnt_lo_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_CNT_HI) cnt_hi_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_ACQCFG) acqcfg_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_SCANCNT) scancnt_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_SCANPER) scanper_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_DACCFG) daccfg_r <= HWDATA;
        else if (wr_addr_r == acq_pkg::OFS_DACPER) dacper_r <= HWDATA;
      end
    end
  end

  // Per-channel range and input type table
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_idx_r <= 6'h00;
      for (int i = 0; i < 64; i++) cfg_r[i] <= 4'h0;
    end else if (wr_pend_r && wr_addr_r == acq_pkg::OFS_CHCFG) begin
      cfg_idx_r <= HWDATA[acq_pkg::CHCFG_IDX +: 6];
      cfg_r[HWDATA[acq_pkg::CHCFG_IDX +: 6]] <= HWDATA[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger conditions
  assign mode = acq_pkg::acq_mode_e'(ctrl_r[acq_pkg::CTRL_MODE +: 3]);
  assign is_fixed = (mode == acq_pkg::M_FIXPRE_STOP) || (mode == acq_pkg::M_FIXPRE_INF);
  assign is_nopre = (mode == acq_pkg::M_NOPRE_STOP) || (mode == acq_pkg::M_NOPRE_INF);
  assign is_inf = (mode == acq_pkg::M_NOPRE_INF) || (mode == acq_pkg::M_FIXPRE_INF)
                  || (mode == acq_pkg::M_VARPRE_INF);
  assign samp_in = ADC_VALID && (state_r != acq_pkg::ST_IDLE);
  assign a_ch = samp_in && (ADC_SAMPLE_CHAN == ctrl_r[acq_pkg::CTRL_ACHAN +: 6]);
  assign thr_plus = {1'b0, atrig_r[15:0]} + {1'b0, atrig_r[31:16]};
  assign smp_plus = {1'b0, ADC_DATA} + {1'b0, atrig_r[31:16]};
  assign a_hit = a_ch && a_armed_r && (ctrl_r[acq_pkg::CTRL_AFALL] ?
                 (ADC_DATA <= atrig_r[15:0]) : (ADC_DATA >= atrig_r[15:0]));

  // Level and edge of the digital trigger line
  always_comb begin
    case (ctrl_r[acq_pkg::CTRL_DMODE +: 2])
      2'h0: d_hit = dtrig_s_r;
      2'h1: d_hit = ~dtrig_s_r;
      2'h2: d_hit = dtrig_s_r & ~dtrig_d_r;
      default: d_hit = ~dtrig_s_r & dtrig_d_r;
    endcase
  end

  assign p_hit = (((din_s_r ^ pattern_r[15:0]) & pattern_r[31:16]) == 16'h0000);

  // Counter reach, exceed, window
  always_comb begin
    case (ctrl_r[acq_pkg::CTRL_CMODE +: 2])
      2'h0: c_hit = (CNT_VALUE == cnt_lo_r);
      2'h1: c_hit = (CNT_VALUE > cnt_lo_r);
      default: c_hit = (CNT_VALUE >= cnt_lo_r) && (CNT_VALUE <= cnt_hi_r);
    endcase
  end

  // Source selection for start and stop
  always_comb begin
    case (acq_pkg::trig_src_e'(ctrl_r[acq_pkg::CTRL_START +: 3]))
      acq_pkg::SRC_DIGITAL: start_cond = d_hit;
      acq_pkg::SRC_ANALOG: start_cond = a_hit;
      acq_pkg::SRC_PATTERN: start_cond = p_hit;
      acq_pkg::SRC_COUNTER: start_cond = c_hit;
      default: start_cond = 1'b1;
    endcase
    case (acq_pkg::trig_src_e'(ctrl_r[acq_pkg::CTRL_STOP +: 3]))
      acq_pkg::SRC_DIGITAL: stop_cond = d_hit;
      acq_pkg::SRC_ANALOG: stop_cond = a_hit;
      acq_pkg::SRC_PATTERN: stop_cond = p_hit;
      acq_pkg::SRC_COUNTER: stop_cond = c_hit;
      default: stop_cond = (scancnt_r != 32'h0) && (scans_r >= scancnt_r) && !conv_busy_r
                           && !ADC_CONVERT && !conv_wait_r;
    endcase
  end

  // Analog hysteresis re-arm
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) a_armed_r <= 1'b0;
    else if (arm_r || a_hit) a_armed_r <= 1'b0;
    else if (a_ch && (ctrl_r[acq_pkg::CTRL_AFALL] ? ({1'b0, ADC_DATA} > thr_plus)
             : (smp_plus < {1'b0, atrig_r[15:0]}))) a_armed_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer
  assign pre_eff = is_nopre ? 5'h00 : {1'b0, acqcfg_r[3:0]};
  assign pre_ok = !is_fixed || (fill >= pre_eff);
  assign trig_fire = (state_r == acq_pkg::ST_PRE) && start_cond && pre_ok && !halt_r;
  assign stop_fire = stop_cond && !is_inf;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acq_pkg::ST_IDLE: if (arm_r) state_nxt = acq_pkg::ST_PRE;
      acq_pkg::ST_PRE: begin
        if (halt_r) state_nxt = acq_pkg::ST_IDLE;
        else if (trig_fire) state_nxt = acq_pkg::ST_POST;
      end
      acq_pkg::ST_POST: if (halt_r || stop_fire) state_nxt = acq_pkg::ST_IDLE;
      default: state_nxt = acq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= acq_pkg::ST_IDLE;
      TRIG_PULSE <= 1'b0;
    end else begin
      state_r <= state_nxt;
      TRIG_PULSE <= trig_fire;
    end
  end

  // Circular pre-trigger store; reader lags the writer by the window
  assign fill = wr_ptr_r - rd_ptr_r;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 16; i++) mem_r[i] <= 16'h0000;
      wr_ptr_r <= 5'h00;
    end else if (samp_in) begin
      mem_r[wr_ptr_r[3:0]] <= ADC_DATA;
      wr_ptr_r <= wr_ptr_r + 5'h01;
    end
  end

  // Reader: discard oldest while waiting, drain to DMA after trigger
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_ptr_r <= 5'h00;
      SAMPLE_VALID <= 1'b0;
      SAMPLE_DATA <= 16'h0000;
    end else begin
      SAMPLE_VALID <= 1'b0;
      if (state_r == acq_pkg::ST_IDLE && arm_r) begin
        rd_ptr_r <= wr_ptr_r;
      end else if (state_r == acq_pkg::ST_PRE) begin
        if (samp_in && fill == pre_eff && !trig_fire) rd_ptr_r <= rd_ptr_r + 5'h01;
      end else if (fill != 5'h00) begin
        SAMPLE_VALID <= 1'b1;
        SAMPLE_DATA <= mem_r[rd_ptr_r[3:0]];
        rd_ptr_r <= rd_ptr_r + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan pacing and per-channel conversion slots
  assign nchan = (acqcfg_r[acq_pkg::ACQ_NCHAN +: 7] == 7'h00) ? 7'h01
                 : acqcfg_r[acq_pkg::ACQ_NCHAN +: 7];
  assign scan_pulse = ctrl_r[acq_pkg::CTRL_EXTSCAN] ? ext_rise : scan_tmr;

  pace_timer u_scan_tmr (
    .clk(REF_CLK),
    .rstn(RSTN),
    .run(state_r != acq_pkg::ST_IDLE),
    .tick(ctrl_r[acq_pkg::CTRL_COARSE] ? coarse_tick_r : us_tick_r),
    .period(scanper_r),
    .pulse(scan_tmr)
  );

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      conv_busy_r <= 1'b0;
      chan_idx_r <= 7'h00;
      scans_r <= 32'h0000_0000;
      ADC_CONVERT <= 1'b0;
      ADC_CHAN <= 6'h00;
      ADC_RANGE <= 3'h0;
      ADC_DIFF <= 1'b0;
    end else begin
      ADC_CONVERT <= 1'b0;
      if (trig_fire) scans_r <= 32'h0000_0000;
      if (state_r == acq_pkg::ST_IDLE) begin
        conv_busy_r <= 1'b0;
      end else if (scan_pulse && !conv_busy_r) begin
        conv_busy_r <= 1'b1;
        chan_idx_r <= 7'h00;
        if (state_r == acq_pkg::ST_POST) scans_r <= scans_r + 32'h0000_0001;
      end else if (us_tick_r && conv_busy_r) begin
        ADC_CONVERT <= 1'b1;
        ADC_CHAN <= chan_idx_r[5:0];
        ADC_RANGE <= cfg_r[chan_idx_r[5:0]][2:0];
        ADC_DIFF <= cfg_r[chan_idx_r[5:0]][3];
        chan_idx_r <= chan_idx_r + 7'h01;
        if (chan_idx_r + 7'h01 >= nchan) conv_busy_r <= 1'b0;
      end
    end
  end

  // Converter result still owed; keeps scan-count stop from losing it; set wins
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) conv_wait_r <= 1'b0;
    else if (ADC_CONVERT) conv_wait_r <= 1'b1;
    else if (ADC_VALID) conv_wait_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output converter pacing, immediate writes and calibration select
  pace_timer u_dac_tmr (
    .clk(REF_CLK),
    .rstn(RSTN),
    .run(daccfg_r[acq_pkg::DAC_STREAM +: 4] != 4'h0),
    .tick(coarse_tick_r),
    .period(dacper_r),
    .pulse(dac_tmr)
  );

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DAC_UPDATE <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        case (daccfg_r[2*i +: 2])
          2'h0: DAC_UPDATE[i] <= daccfg_r[acq_pkg::DAC_STREAM + i] & dac_tmr;
          2'h1: DAC_UPDATE[i] <= daccfg_r[acq_pkg::DAC_STREAM + i] & scan_tmr & !conv_busy_r;
          default: DAC_UPDATE[i] <= daccfg_r[acq_pkg::DAC_STREAM + i] & ext_rise;
        endcase
      end
    end
  end

  // Immediate value refused while that converter streams
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DAC_IMM_WE <= 4'h0;
      DAC_IMM_DATA <= 16'h0000;
    end else begin
      DAC_IMM_WE <= 4'h0;
      if (wr_pend_r && wr_addr_r == acq_pkg::OFS_DACIMM) begin
        DAC_IMM_DATA <= HWDATA[15:0];
        if (!daccfg_r[acq_pkg::DAC_STREAM + HWDATA[acq_pkg::DACIMM_IDX +: 2]]) begin
          DAC_IMM_WE[HWDATA[acq_pkg::DACIMM_IDX +: 2]] <= 1'b1;
        end
      end
    end
  end

  // Table 0 is factory and never a write target
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CAL_SEL <= 2'h0;
      CAL_WR_TABLE <= 2'h0;
      CAL_WR_OK <= 1'b0;
    end else begin
      CAL_SEL <= (daccfg_r[acq_pkg::DAC_CALSEL +: 2] == 2'h3) ? 2'h0
                 : daccfg_r[acq_pkg::DAC_CALSEL +: 2];
      CAL_WR_TABLE <= daccfg_r[acq_pkg::DAC_CALWR +: 2];
      CAL_WR_OK <= (daccfg_r[acq_pkg::DAC_CALWR +: 2] == 2'h1)
                   || (daccfg_r[acq_pkg::DAC_CALWR +: 2] == 2'h2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_fire;
    state_r == acq_pkg::ST_PRE && trig_fire;
  endsequence
  property p_trig_post;
    s_fire |=> state_r == acq_pkg::ST_POST && TRIG_PULSE ##1 !TRIG_PULSE;
  endproperty
  a_trig_post: assert property (p_trig_post) else $error("trigger did not start post");
  property p_conv_gap;
    ADC_CONVERT |=> !ADC_CONVERT [*8];
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion slots too close");
  property p_halt;
    halt_r && state_r != acq_pkg::ST_IDLE |=> state_r == acq_pkg::ST_IDLE;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  property p_fixed_full;
    trig_fire && is_fixed |-> fill >= pre_eff;
  endproperty
  a_fixed_full: assert property (p_fixed_full) else $error("fixed pre window short");
  property p_ring;
    state_r == acq_pkg::ST_PRE && !$past(trig_fire) |-> fill <= pre_eff + 5'h01;
  endproperty
  a_ring: assert property (p_ring) else $error("pre store over window");
  property p_inf;
    state_r == acq_pkg::ST_POST && is_inf && !halt_r |=> state_r == acq_pkg::ST_POST;
  endproperty
  a_inf: assert property (p_inf) else $error("unlimited mode ended early");
  property p_stream;
    DAC_UPDATE[0] |-> $past(daccfg_r[acq_pkg::DAC_STREAM]);
  endproperty
  a_stream: assert property (p_stream) else $error("update on idle converter");
  property p_cal;
    CAL_WR_OK |-> CAL_WR_TABLE != 2'h0 && $past(daccfg_r[acq_pkg::DAC_CALWR +: 2]) != 2'h0;
  endproperty
  a_cal: assert property (p_cal) else $error("factory table writable");

endmodule : acq_trigger_pacing

// File: hdl/pace_timer.sv
// Programmable period timer producing one-cycle pace pulses.
// Assumes a one-cycle tick input on the same clock.
`timescale 1ns/1ps
module pace_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic tick,
  input wire logic [31:0] period,
  output logic pulse
);

  logic [31:0] cnt_r;

  // Count ticks, fire when period reached
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 32'h0000_0000;
      pulse <= 1'b0;
    end else if (!run) begin
      cnt_r <= 32'h0000_0000;
      pulse <= 1'b0;
    end else if (tick && (cnt_r + 32'h0000_0001 >= period)) begin
      cnt_r <= 32'h0000_0000;
      pulse <= 1'b1;
    end else begin
      cnt_r <= tick ? cnt_r + 32'h0000_0001 : cnt_r;
      pulse <= 1'b0;
    end
  end

endmodule : pace_timer

// File: tb/acq_trigger_pacing_bench.sv
// Self-checking bench for the trigger and pacing block.
// Assumes a zero-wait AHB-Lite slave and the host model beside it.
`timescale 1ns/1ps
module acq_trigger_pacing_bench;
  logic ref_clk = 0, rstn = 0, hsel = 0, hwrite = 0, dtrig = 0, av = 0, ac, sv, tp, okw;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, cs, cw;
  logic [15:0] din = 0, ad = 0, sd, imd, pv, pm;
  logic [5:0] ach = 0, adc_chan;
  logic [3:0] du, iwe;
  logic hro, hresp, adif;
  logic [2:0] arng;
  int error_cnt = 0, total_checks = 0, cyc = 0, ntrig = 0, nimm = 0, ns, nd, n0;
  logic [15:0] ls;
  always #12.5 ref_clk = ~ref_clk;
  acq_trigger_pacing dut (.REF_CLK(ref_clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro),
    .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hresp), .DTRIG_IN(dtrig), .DIN(din),
    .EXT_CLK(1'b0), .CNT_VALUE(32'h0000_0000), .ADC_VALID(av), .ADC_DATA(ad),
    .ADC_SAMPLE_CHAN(ach), .ADC_CONVERT(ac), .ADC_CHAN(adc_chan), .ADC_RANGE(arng),
    .ADC_DIFF(adif), .SAMPLE_VALID(sv), .SAMPLE_DATA(sd), .TRIG_PULSE(tp), .DAC_UPDATE(du),
    .DAC_IMM_WE(iwe), .DAC_IMM_DATA(imd), .CAL_SEL(cs), .CAL_WR_TABLE(cw), .CAL_WR_OK(okw));
  host_dma_sink host (.clk(ref_clk), .rstn(rstn), .sample_valid(sv), .sample_data(sd),
    .dac_update(du), .n_samples(ns), .last_sample(ls), .n_dac0(nd));
  ////////////////////////////////////////////////////////////////////////////
  // Converter answers one edge later; pulse counters; hang guard
  always @(posedge ref_clk) begin
    av <= ac;
    ad <= 16'($urandom);
    ach <= adc_chan;
    ntrig <= ntrig + (tp === 1'b1);
    nimm <= nimm + (iwe !== 4'h0);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles and comparisons
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge ref_clk);
    while (hro !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hro !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic waitn(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : waitn
  // Expected pattern hit: compared bits of the inputs equal the value
  function automatic int pat_hit(input logic [15:0] v, input logic [15:0] m,
                                 input logic [15:0] d);
    return (((d ^ v) & m) == 16'h0000) ? 1 : 0;
  endfunction : pat_hit
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h16a99a58));
    waitn(12);
    rstn <= 1'b1;
    @(posedge ref_clk);
    xfer(0, acq_pkg::OFS_SCANPER, 0); chk("scanper", acq_pkg::SCANPER_RST, rd);
    xfer(0, acq_pkg::OFS_ACQCFG, 0); chk("acqcfg", acq_pkg::ACQCFG_RST, rd);
    xfer(0, 8'hFC, 0); chk("unmapped", 32'h0, rd);
    xfer(1, acq_pkg::OFS_CHCFG, 32'h0001_000B);
    xfer(0, acq_pkg::OFS_CHCFG, 0); chk("chcfg", 32'h0001_000B, rd);
    chk("hresp", 32'h0, hresp);
    $display("test regs done");
    // Digital level start, scan-count stop, two channels per scan
    xfer(1, acq_pkg::OFS_ACQCFG, 32'h0000_0200);
    xfer(1, acq_pkg::OFS_SCANPER, 32'h3);
    xfer(1, acq_pkg::OFS_SCANCNT, 32'h2);
    xfer(1, acq_pkg::OFS_CTRL, 32'h0000_0401);
    waitn(40);
    xfer(0, acq_pkg::OFS_STATUS, 0); chk("pre", 32'h1, rd & 32'h3);
    n0 = ns;
    dtrig <= 1'b1;
    waitn(1200);
    dtrig <= 1'b0;
    chk("one pulse", 32'h1, ntrig);
    xfer(0, acq_pkg::OFS_STATUS, 0); chk("idle", 32'h0, rd & 32'h3);
    chk("samples", 32'h1, (ns - n0) >= 4);
    chk("range", 32'hB, {adif, arng});
    $display("test digital done");
    // Masked pattern: mismatch on a compared bit, then masked bits only
    pv = 16'($urandom);
    pm = 16'($urandom) | 16'h0001;
    xfer(1, acq_pkg::OFS_PATTERN, {pm, pv});
    din <= pv ^ 16'h0001;
    xfer(1, acq_pkg::OFS_CTRL, 32'h0000_0849);
    waitn(300); chk("no match", 32'(1 + pat_hit(pv, pm, pv ^ 16'h0001)), ntrig);
    din <= pv ^ ~pm;
    waitn(300); chk("match", 32'(1 + pat_hit(pv, pm, pv ^ ~pm)), ntrig);
    xfer(1, acq_pkg::OFS_CTRL, 32'h0000_0002);
    waitn(4);
    xfer(0, acq_pkg::OFS_STATUS, 0); chk("halt", 32'h0, rd & 32'h3);
    $display("test pattern done");
    // Fixed pre-trigger of three, pattern start, digital level stop
    xfer(1, acq_pkg::OFS_ACQCFG, 32'h0000_0203);
    n0 = ns;
    xfer(1, acq_pkg::OFS_CTRL, 32'h0000_0045);
    waitn(400); chk("pre trig", 32'h3, ntrig);
    chk("pre samples", 32'h1, (ns - n0) >= 3);
    dtrig <= 1'b1;
    waitn(8);
    xfer(0, acq_pkg::OFS_STATUS, 0); chk("stopped", 32'h0, rd & 32'h3);
    dtrig <= 1'b0;
    $display("test pretrigger done");
    // Timer paced stream on converter 0, immediate writes, tables
    xfer(1, acq_pkg::OFS_DACCFG, 32'h0000_6100);
    waitn(1400); chk("paced", 32'h1, nd >= 1);
    chk("cal sel", 32'h2, cs);
    chk("cal wr", 32'h1, okw);
    chk("cal target", 32'h1, cw);
    xfer(1, acq_pkg::OFS_DACCFG, 32'h0000_0100);
    waitn(2); chk("factory", 32'h0, okw);
    xfer(1, acq_pkg::OFS_DACIMM, 32'h0000_1234);
    xfer(1, acq_pkg::OFS_DACIMM, 32'h0001_BEEF);
    waitn(4); chk("imm count", 32'h1, nimm);
    chk("imm data", 32'hBEEF, imd);
    $display("test converter done");
    close_out();
  end
endmodule : acq_trigger_pacing_bench

// File: tb/host_dma_sink.sv
// Host side model: takes streamed samples and converter fetches.
// Assumes the DMA strobes are one-cycle pulses on the board clock.
`timescale 1ns/1ps
module host_dma_sink (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  input wire logic [3:0] dac_update,
  output int n_samples,
  output logic [15:0] last_sample,
  output int n_dac0
);
  // Count input samples and converter 0 fetches, no back-pressure
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n_samples <= 0;
      n_dac0 <= 0;
      last_sample <= 16'h0000;
    end else begin
      if (sample_valid === 1'b1) begin
        n_samples <= n_samples + 1;
        last_sample <= sample_data;
      end
      if (dac_update[0] === 1'b1) n_dac0 <= n_dac0 + 1;
    end
  end
endmodule : host_dma_sink
